// ===== design/ijx_pkg.sv
// constants shared by the increment and jump execution block
package ijx_pkg;
	// bus map, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_INSTR = 8'h04;
	localparam logic [7:0] REG_NEXT = 8'h08;
	localparam logic [7:0] REG_BSR = 8'h0C;
	localparam logic [7:0] REG_WREG = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_PC = 8'h18;
	localparam logic [7:0] REG_FADDR = 8'h1C;
	localparam logic [7:0] REG_FDATA = 8'h20;
	localparam logic [7:0] REG_FSR = 8'h24;
	// field positions
	localparam int CTRL_EXT_BIT = 0;
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;
	localparam int ST_OV = 3;
	localparam int ST_N = 4;
	localparam int ST_BUSY = 8;
	localparam int ST_SKIP = 9;
	localparam int ST_ILL = 10;
	localparam int FLAG_W = 5;
	localparam int INSTR_D_BIT = 9;
	localparam int INSTR_A_BIT = 8;
	// widths
	localparam int PC_W = 21;
	localparam int BSR_W = 4;
	localparam int FULL_AW = 12;
	// opcodes
	localparam logic [5:0] OPC_INC = 6'h0A;
	localparam logic [5:0] OPC_INCSZ = 6'h0F;
	localparam logic [7:0] OPC_JMP_W1 = 8'hEF;
	localparam logic [7:0] ACC_SPLIT = 8'h5F;
	localparam logic [3:0] BANK_LO = 4'h0;
	localparam logic [3:0] BANK_HI = 4'hF;
	// reset values and steps
	localparam logic [PC_W-1:0] PC_RST = 21'h0_0000;
	localparam logic [PC_W-1:0] PC_STEP = 21'h0_0002;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// quarter phases
	localparam logic [1:0] Q1 = 2'h0;
	localparam logic [1:0] Q2 = 2'h1;
	localparam logic [1:0] Q3 = 2'h2;
	localparam logic [1:0] Q4 = 2'h3;
	typedef enum logic [1:0] {EX_IDLE, EX_WAIT, EX_RUN, EX_NOP} ijx_ex_t;
	typedef enum logic [1:0] {OP_NONE, OP_INC, OP_INCSZ, OP_JMP} ijx_op_t;
endpackage : ijx_pkg

// ===== design/ijx_q_if.sv
// quarter phase strobe carrier between the phase divider and the core
`timescale 1ns/1ns
interface ijx_q_if;
	logic q_en;
	logic [1:0] q_num;
	modport src (output q_en, output q_num);
	modport snk (input q_en, input q_num);
endinterface : ijx_q_if

// ===== design/ijx_qphase.sv
// quarter phase divider: one enable pulse per quarter, numbered Q1 to Q4
`timescale 1ns/1ns
module ijx_qphase import ijx_pkg::*; #(
	parameter int QDIV = 1
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// phase strobe
	ijx_q_if.src qp
);
	localparam int CW = $clog2(QDIV + 1);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic en;
		logic [1:0] q;
	} ijx_qs_t;
	ijx_qs_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.en = 1'b0;
		if (s_q.cnt == CW'(QDIV - 1)) begin
			s_d.cnt = '0;
			s_d.en = 1'b1;
			s_d.q = s_q.q + 2'h1;
		end else begin
			s_d.cnt = s_q.cnt + CW'(1);
		end
	end

	// quarter counter starts at Q4 so the first pulse is Q1
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '{cnt: '0, en: 1'b0, q: Q4};
		end else begin
			s_q <= s_d;
		end
	end

	assign qp.q_en = s_q.en;
	assign qp.q_num = s_q.q;
endmodule : ijx_qphase

// ===== design/ijx_core.sv
// increment and long jump execution core with its register slave
`timescale 1ns/1ns
module ijx_core import ijx_pkg::*; #(
	parameter int FILE_AW = 9,
	parameter int QDIV = 1
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	localparam int FILE_N = 1 << FILE_AW;
	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic rd_pend;
		logic [7:0] rd_addr;
		logic ext;
		logic [15:0] instr;
		logic [15:0] next;
		logic [BSR_W-1:0] bank_select_register;
		logic [7:0] wreg;
		logic [FLAG_W-1:0] flags;
		logic skipped;
		logic ill;
		logic [PC_W-1:0] pc;
		logic [FILE_AW-1:0] faddr;
		logic [FULL_AW-1:0] fsr;
		ijx_ex_t ex;
		ijx_op_t op;
		logic [FILE_AW-1:0] eaddr;
		logic [7:0] opnd;
		logic [8:0] sum;
		logic [7:0] klo;
		logic [1:0] nops;
		logic nop_step;
		logic [FILE_N-1:0][7:0] mem;
	} ijx_st_t;
	ijx_st_t s_q, s_d;

	ijx_q_if qp ();

	ijx_qphase #(.QDIV(QDIV)) u_qphase (
		.hclk(hclk),
		.hresetn(hresetn),
		.qp(qp.src)
	);

	function automatic logic [FILE_AW-1:0] eff_addr(input logic [7:0] f, input logic a,
		input logic [BSR_W-1:0] bank_select_register, input logic ext, input logic [FULL_AW-1:0] fsr);
		logic [FULL_AW-1:0] full;
		full = {bank_select_register, f};
		if (!a) begin
			if (ext && f <= ACC_SPLIT) begin
				full = fsr + {BANK_LO, f};
			end else if (f <= ACC_SPLIT) begin
				full = {BANK_LO, f};
			end else begin
				full = {BANK_HI, f};
			end
		end
		return full[FILE_AW-1:0];
	endfunction : eff_addr

	function automatic logic is_two_word(input logic [15:0] w);
		return w[15:8] == OPC_JMP_W1;
	endfunction : is_two_word

	function automatic logic [PC_W-1:0] step_pc(input logic [PC_W-1:0] pc);
		return pc + PC_STEP;
	endfunction : step_pc

	function automatic logic [FLAG_W-1:0] inc_flags(input logic [FLAG_W-1:0] old, input logic [7:0] opnd,
		input logic [8:0] sum);
		logic [FLAG_W-1:0] f;
		f = old;
		f[ST_C] = sum[8];
		f[ST_DC] = (opnd[3:0] == 4'hF);
		f[ST_N] = sum[7];
		f[ST_OV] = (opnd == 8'h7F);
		f[ST_Z] = (sum[7:0] == BYTE_RST);
		return f;
	endfunction : inc_flags

	function automatic ijx_op_t decode(input logic [15:0] w);
		if (w[15:10] == OPC_INC) begin
			return OP_INC;
		end else if (w[15:10] == OPC_INCSZ) begin
			return OP_INCSZ;
		end else if (is_two_word(w)) begin
			return OP_JMP;
		end
		return OP_NONE;
	endfunction : decode

	function automatic logic [31:0] rd_word(input ijx_st_t st, input logic [7:0] a);
		logic [31:0] r;
		r = '0;
		if (a == REG_CTRL) begin
			r[CTRL_EXT_BIT] = st.ext;
		end else if (a == REG_INSTR) begin
			r[15:0] = st.instr;
		end else if (a == REG_NEXT) begin
			r[15:0] = st.next;
		end else if (a == REG_BSR) begin
			r[BSR_W-1:0] = st.bank_select_register;
		end else if (a == REG_WREG) begin
			r[7:0] = st.wreg;
		end else if (a == REG_STATUS) begin
			r[FLAG_W-1:0] = st.flags;
			r[ST_BUSY] = (st.ex != EX_IDLE);
			r[ST_SKIP] = st.skipped;
			r[ST_ILL] = st.ill;
		end else if (a == REG_PC) begin
			r[PC_W-1:0] = st.pc;
		end else if (a == REG_FADDR) begin
			r[FILE_AW-1:0] = st.faddr;
		end else if (a == REG_FDATA) begin
			r[7:0] = st.mem[st.faddr];
		end else if (a == REG_FSR) begin
			r[FULL_AW-1:0] = st.fsr;
		end
		return r;
	endfunction : rd_word

	always_comb begin
		s_d = s_q;
		// bus data phase: a read right behind a write waits one cycle so it sees the write
		if (s_q.rd_pend) begin
			s_d.hrdata = rd_word(s_q, s_q.rd_addr);
			s_d.hreadyout = 1'b1;
			s_d.rd_pend = 1'b0;
		end
		if (s_q.wr_pend) begin
			s_d.wr_pend = 1'b0;
			if (s_q.wr_addr == REG_CTRL) begin
				s_d.ext = hwdata[CTRL_EXT_BIT];
			end else if (s_q.wr_addr == REG_INSTR) begin
				// a new instruction is refused while one is still running
				if (s_q.ex == EX_IDLE) begin
					s_d.instr = hwdata[15:0];
					s_d.ex = EX_WAIT;
					s_d.skipped = 1'b0;
					s_d.ill = 1'b0;
				end
			end else if (s_q.wr_addr == REG_NEXT) begin
				s_d.next = hwdata[15:0];
			end else if (s_q.wr_addr == REG_BSR) begin
				s_d.bank_select_register = hwdata[BSR_W-1:0];
			end else if (s_q.wr_addr == REG_WREG) begin
				s_d.wreg = hwdata[7:0];
			end else if (s_q.wr_addr == REG_STATUS) begin
				s_d.flags = hwdata[FLAG_W-1:0];
			end else if (s_q.wr_addr == REG_PC) begin
				s_d.pc = hwdata[PC_W-1:0];
			end else if (s_q.wr_addr == REG_FADDR) begin
				s_d.faddr = hwdata[FILE_AW-1:0];
			end else if (s_q.wr_addr == REG_FDATA) begin
				s_d.mem[s_q.faddr] = hwdata[7:0];
			end else if (s_q.wr_addr == REG_FSR) begin
				s_d.fsr = hwdata[FULL_AW-1:0];
			end
		end
		// bus address phase
		if (hsel && htrans[1] && hready) begin
			if (hwrite) begin
				s_d.wr_pend = 1'b1;
				s_d.wr_addr = haddr[7:0];
			end else if (s_q.wr_pend) begin
				s_d.rd_pend = 1'b1;
				s_d.rd_addr = haddr[7:0];
				s_d.hreadyout = 1'b0;
			end else begin
				s_d.hrdata = rd_word(s_q, haddr[7:0]);
			end
		end
		// execution, stepped by quarter phases; its writes win over a bus write
		if (qp.q_en) begin
			case (s_q.ex)
				EX_WAIT: begin
					if (qp.q_num == Q1) begin
						s_d.op = decode(s_q.instr);
						s_d.eaddr = eff_addr(s_q.instr[7:0], s_q.instr[INSTR_A_BIT], s_q.bank_select_register, s_q.ext, s_q.fsr);
						s_d.ex = EX_RUN;
					end
				end
				EX_RUN: begin
					case (qp.q_num)
						Q2: begin
							s_d.klo = s_q.instr[7:0];
							s_d.opnd = s_q.mem[s_q.eaddr];
						end
						Q3: begin
							s_d.sum = {1'b0, s_q.opnd} + 9'h001;
						end
						Q4: begin
							s_d.ex = EX_IDLE;
							if (s_q.op == OP_JMP) begin
								s_d.pc = {s_q.next[11:0], s_q.klo, 1'b0};
								s_d.nops = 2'h1;
								s_d.nop_step = 1'b0;
								s_d.ex = EX_NOP;
							end else if (s_q.op == OP_NONE) begin
								s_d.ill = 1'b1;
							end else begin
								if (s_q.instr[INSTR_D_BIT]) begin
									s_d.mem[s_q.eaddr] = s_q.sum[7:0];
								end else begin
									s_d.wreg = s_q.sum[7:0];
								end
								s_d.pc = step_pc(s_q.pc);
								if (s_q.op == OP_INC) begin
									s_d.flags = inc_flags(s_q.flags, s_q.opnd, s_q.sum);
								end else if (s_q.sum[7:0] == BYTE_RST) begin
									// the fetched word is dropped; a two-word one costs a second idle cycle
									s_d.skipped = 1'b1;
									s_d.nops = is_two_word(s_q.next) ? 2'h2 : 2'h1;
									s_d.nop_step = 1'b1;
									s_d.ex = EX_NOP;
								end
							end
						end
						default: begin
						end
					endcase
				end
				EX_NOP: begin
					if (qp.q_num == Q4) begin
						if (s_q.nop_step) begin
							s_d.pc = step_pc(s_q.pc);
						end
						s_d.nops = s_q.nops - 2'h1;
						if (s_q.nops == 2'h1) begin
							s_d.ex = EX_IDLE;
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q.hrdata <= '0;
			s_q.hreadyout <= 1'b1;
			s_q.hresp <= 1'b0;
			s_q.wr_pend <= 1'b0;
			s_q.wr_addr <= BYTE_RST;
			s_q.rd_pend <= 1'b0;
			s_q.rd_addr <= BYTE_RST;
			s_q.ext <= 1'b0;
			s_q.instr <= '0;
			s_q.next <= '0;
			s_q.bank_select_register <= '0;
			s_q.wreg <= BYTE_RST;
			s_q.flags <= '0;
			s_q.skipped <= 1'b0;
			s_q.ill <= 1'b0;
			s_q.pc <= PC_RST;
			s_q.faddr <= '0;
			s_q.fsr <= '0;
			s_q.ex <= EX_IDLE;
			s_q.op <= OP_NONE;
			s_q.eaddr <= '0;
			s_q.opnd <= BYTE_RST;
			s_q.sum <= '0;
			s_q.klo <= BYTE_RST;
			s_q.nops <= '0;
			s_q.nop_step <= 1'b0;
			s_q.mem <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign hrdata = s_q.hrdata;
	assign hreadyout = s_q.hreadyout;
	// every transfer is served alike, hsize unread, and hresp keeps its reset value, so the response never leaves okay
	assign hresp = s_q.hresp;
endmodule : ijx_core

// ===== verification/ijx_core_checker.sv
// bus checks for the increment and jump core
`timescale 1ns/1ns
module ijx_core_checker import ijx_pkg::*; (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp
);
	logic rd_q;
	logic [7:0] adr_q;
	logic acc;
	logic ans;
	assign acc = hsel && htrans[1] && hready;
	assign ans = rd_q && hreadyout;
	// held across a wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 1'b0;
			adr_q <= 8'h00;
		end else if (hreadyout) begin
			rd_q <= acc && !hwrite;
			adr_q <= haddr[7:0];
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("error response");
	property p_wait_one; !hreadyout |=> hreadyout; endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait too long");
	property p_wait_cause; !hreadyout |-> $past(acc && !hwrite) && $past(acc && hwrite, 2); endproperty
	a_wait_cause: assert property (p_wait_cause) else $error("wait without cause");
	property p_hold; $changed(hrdata) |-> rd_q; endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_unmap; ans && adr_q >= 8'h28 |-> hrdata == 32'h0000_0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped not zero");
	property p_pc; ans && adr_q == REG_PC |-> hrdata[0] == 1'b0 && hrdata[31:21] == 11'h000; endproperty
	a_pc: assert property (p_pc) else $error("pc shape");
	property p_flags; ans && adr_q == REG_STATUS |-> hrdata[31:11] == 21'h00_0000 && hrdata[7:5] == 3'h0; endproperty
	a_flags: assert property (p_flags) else $error("status shape");
	property p_bank; ans && adr_q == REG_BSR |-> hrdata[31:4] == 28'h000_0000; endproperty
	a_bank: assert property (p_bank) else $error("bank shape");
endmodule : ijx_core_checker
bind ijx_core ijx_core_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp));

// ===== verification/tb_top.sv
// self-checking bench for the increment and jump core
`timescale 1ns/1ns
module tb_top import ijx_pkg::*;;
	typedef struct {logic [7:0] a; logic [31:0] m; logic [31:0] e;} ijx_note_t;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic rd_ph = 1'b0;
	ijx_note_t notes[$];
	ijx_note_t n;
	int errors = 0;
	int comparisons = 0;
	int cyc = 0;
	int seed = 32'h4691;
	logic [31:0] r;
	logic [31:0] pc0;
	logic [7:0] v;
	logic [7:0] s;
	always #4 hclk = ~hclk;
	ijx_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic summarize();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize
	// single word transfer; hready waits have no bound of their own
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_ph <= 1'b0;
		r = hrdata;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		notes.push_back('{a, m, e});
		xfer(1'b0, a, 32'h0000_0000);
	endtask : rd
	task automatic put(input logic [8:0] a, input logic [7:0] d);
		wr(REG_FADDR, {23'h00_0000, a});
		wr(REG_FDATA, {24'h00_0000, d});
	endtask : put
	task automatic get(input logic [8:0] a, input logic [7:0] e);
		wr(REG_FADDR, {23'h00_0000, a});
		rd(REG_FDATA, 32'hFFFF_FFFF, {24'h00_0000, e});
	endtask : get
	task automatic run(input logic [15:0] ins);
		wr(REG_INSTR, {16'h0000, ins});
		do rd(REG_STATUS, 32'hFFFF_F8E0, 32'h0000_0000); while (r[ST_BUSY] !== 1'b0);
	endtask : run
	// watcher: compares each read answer with the oldest note
	always @(posedge hclk) begin
		cyc++;
		if (rd_ph && hreadyout === 1'b1 && notes.size() > 0) begin
			n = notes.pop_front();
			chk($sformatf("reg %h", n.a), hrdata & n.m, n.e);
		end
		if (cyc == 6000) begin
			errors++;
			summarize();
		end
	end
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		rd(8'h30, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(REG_BSR, 32'h0000_0001);
		put(9'h105, 8'hFF);
		run(16'h2B05);
		get(9'h105, 8'h00);
		rd(REG_STATUS, 32'h0000_001F, 32'h0000_0007);
		// first pass forces the overflow case
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			v = i == 0 ? 8'h7F : r[7:0];
			s = v + 8'h01;
			put(9'h160, v);
			run(16'h2860);
			rd(REG_WREG, 32'hFFFF_FFFF, {24'h00_0000, s});
			get(9'h160, v);
			rd(REG_STATUS, 32'h0000_001F, {27'h000_0000, s[7], v == 8'h7F, s == 8'h00, v[3:0] == 4'hF, v == 8'hFF});
		end
		wr(REG_CTRL, 32'h0000_0001);
		wr(REG_FSR, 32'h0000_0020);
		wr(REG_STATUS, 32'h0000_000A);
		// no skip, one-word skip, two-word skip
		for (int i = 0; i < 3; i++) begin
			put(9'h030, i == 0 ? 8'h41 : 8'hFF);
			wr(REG_NEXT, i == 2 ? 32'h0000_EF00 : 32'h0000_1234);
			rd(REG_PC, 32'hFFE0_0001, 32'h0000_0000);
			pc0 = r;
			run(16'h3E10);
			get(9'h030, i == 0 ? 8'h42 : 8'h00);
			rd(REG_STATUS, 32'h0000_021F, i == 0 ? 32'h0000_000A : 32'h0000_020A);
			rd(REG_PC, 32'hFFFF_FFFF, pc0 + 2 * (i + 1));
		end
		wr(REG_NEXT, 32'h0000_F123);
		run(16'hEF45);
		rd(REG_PC, 32'hFFFF_FFFF, 32'h0002_468A);
		// unknown opcode: illegal flag only, pc and flags kept
		run(16'h0000);
		rd(REG_STATUS, 32'h0000_071F, 32'h0000_040A);
		rd(REG_PC, 32'hFFFF_FFFF, 32'h0002_468A);
		repeat (2) @(posedge hclk);
		summarize();
	end
endmodule : tb_top
